// ---- pio_cmd_defs.svh ----
// Command codes, reply bytes and reset values for the pin access command layer
`ifndef PIO_CMD_DEFS_SVH
`define PIO_CMD_DEFS_SVH

`define PIO_CMD_READ       8'hF5
`define PIO_CMD_WRITE      8'h5A
`define PIO_CONFIRM_BYTE   8'hAA
`define PIO_ERROR_BYTE     8'hFF
`define PIO_LATCH_RESET    2'h3
`define PIO_LATCH_A_BIT    0
`define PIO_LATCH_B_BIT    1

`endif

// ---- pio_cmd_pkg.sv ----
// Types shared by the pin access command layer
package pio_cmd_pkg;

  typedef logic [7:0] byte_t;

  typedef struct packed
  {
    logic  valid;
    byte_t data;
  } rx_byte_s;

  typedef struct packed
  {
    logic pinB;
    logic pinA;
  } pin_pair_s;

  typedef enum logic [2:0]
  {
    ST_WAIT_SELECT,
    ST_COMMAND,
    ST_READ_LOOP,
    ST_WRITE_DATA,
    ST_WRITE_CHECK,
    ST_WRITE_CONFIRM,
    ST_WRITE_STATUS,
    ST_ERROR_LOOP
  } cmd_state_e;

endpackage : pio_cmd_pkg

// ---- pio_sample_encoder.sv ----
// Registered pin status byte: pin and latch per channel, complemented high nibble
`timescale 1ns/1ps

module pio_sample_encoder
  import pio_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // Channel state
  input  wire pio_cmd_pkg::pin_pair_s pinLevel,
  input  wire logic [1:0]             latchState,
  // Encoded byte
  output      pio_cmd_pkg::byte_t     sampleByte
);

  byte_t sample_reg;
  wire   [3:0] lowNibble;

  assign lowNibble  = {latchState[1], pinLevel.pinB, latchState[0], pinLevel.pinA};
  assign sampleByte = sample_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sample_reg <= 8'hF0;
    else if (ce)
      sample_reg <= {~lowNibble, lowNibble};
  end

endmodule : pio_sample_encoder

// ---- pio_cmd_layer.sv ----
// Pin access command interpreter behind the single-wire link layer
// Operation
// - Code F5h returns sampled channel pin bytes
// - Fresh sample per read byte until reset
// - Read command never aborts or errors
// - Code 5Ah starts output latch update
// - Valid complement applies state, replies AAh
// - Then status byte showing updated pins if AAh waits one cycle untaken
// - Further byte pairs accepted until reset
// - Bad complement enters endless all-ones loop
// - Error loop leaves bus released every slot
// - Reset and presence frame every transaction
`timescale 1ns/1ps
`include "pio_cmd_defs.svh"

module pio_cmd_layer
  import pio_cmd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // Link layer framing
  input  wire logic                   busReset,
  input  wire logic                   romSelected,
  // Bytes from master
  input  wire pio_cmd_pkg::rx_byte_s  rxByte,
  // Bytes to master
  output      logic                   txValid,
  output      pio_cmd_pkg::byte_t     txData,
  input  wire logic                   txReady,
  // Channel A pin
  input  wire logic                   channelAPinIn,
  output      logic                   channelAPinOut,
  output      logic                   channelAPinOeN,
  // Channel B pin
  input  wire logic                   channelBPinIn,
  output      logic                   channelBPinOut,
  output      logic                   channelBPinOeN,
  // Debug flag, high while the command state is the error loop
  output      logic                   errorLoop
);

  cmd_state_e state_reg;
  cmd_state_e state_next;
  logic [1:0] latch_reg;
  logic [1:0] latch_next;
  byte_t      data_reg;
  byte_t      data_next;
  byte_t      tx_reg;
  byte_t      tx_next;
  logic       txv_reg;
  logic       txv_next;
  byte_t      sampleByte;
  pin_pair_s  pinLevel;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic isComplement(input byte_t a, input byte_t b);
    isComplement = ((a ^ b) == 8'hFF);
  endfunction : isComplement

  wire rxGot     = rxByte.valid;
  wire txTaken   = txv_reg & txReady;
  wire isReadCmd  = rxGot && (rxByte.data == `PIO_CMD_READ);
  wire isWriteCmd = rxGot && (rxByte.data == `PIO_CMD_WRITE);
  wire pairGood  = isComplement(data_reg, rxByte.data);

  assign pinLevel.pinA = channelAPinIn;
  assign pinLevel.pinB = channelBPinIn;

  pio_sample_encoder u_encoder
  (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .ce         (ce),
    .pinLevel   (pinLevel),
    .latchState (latch_reg),
    .sampleByte (sampleByte)
  );

  // ---------------------------------------------------------------
  // Open-drain channels
  // ---------------------------------------------------------------
  // A zero latch pulls low; a one releases so the pin can be sensed
  assign channelAPinOut = 1'b0;
  assign channelBPinOut = 1'b0;
  assign channelAPinOeN = latch_reg[`PIO_LATCH_A_BIT];
  assign channelBPinOeN = latch_reg[`PIO_LATCH_B_BIT];

  assign txValid   = txv_reg;
  assign txData    = tx_reg;
  assign errorLoop = (state_reg == ST_ERROR_LOOP);

  // ---------------------------------------------------------------
  // Command sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    latch_next = latch_reg;
    data_next  = data_reg;
    tx_next    = tx_reg;
    txv_next   = txv_reg;
    case (state_reg)
      ST_WAIT_SELECT:
      begin
        txv_next = 1'b0;
        if (romSelected)
          state_next = ST_COMMAND;
      end
      ST_COMMAND:
      begin
        if (isReadCmd)
        begin
          state_next = ST_READ_LOOP;
          tx_next    = sampleByte;
          txv_next   = 1'b1;
        end
        else if (isWriteCmd)
          state_next = ST_WRITE_DATA;
        else if (rxGot)
          state_next = ST_WAIT_SELECT;
      end
      ST_READ_LOOP:
      begin
        // No exit but the bus reset; every slot byte is a new sample
        txv_next = 1'b1;
        if (txTaken)
          tx_next = sampleByte;
      end
      ST_WRITE_DATA:
      begin
        if (rxGot)
        begin
          data_next  = rxByte.data;
          state_next = ST_WRITE_CHECK;
        end
      end
      ST_WRITE_CHECK:
      begin
        if (rxGot && pairGood)
        begin
          latch_next = data_reg[1:0];
          tx_next    = `PIO_CONFIRM_BYTE;
          txv_next   = 1'b1;
          state_next = ST_WRITE_CONFIRM;
        end
        else if (rxGot)
        begin
          // Latch untouched on a bad pair
          tx_next    = `PIO_ERROR_BYTE;
          txv_next   = 1'b1;
          state_next = ST_ERROR_LOOP;
        end
      end
      ST_WRITE_CONFIRM:
      begin
        // Status needs one idle cycle after the check byte: the encoder
        // registers the pins, so an earlier take would report old levels
        if (txTaken)
        begin
          tx_next    = sampleByte;
          state_next = ST_WRITE_STATUS;
        end
      end
      ST_WRITE_STATUS:
      begin
        if (txTaken)
        begin
          txv_next   = 1'b0;
          state_next = ST_WRITE_DATA;
        end
      end
      ST_ERROR_LOOP:
      begin
        // All ones leaves the line released in every read slot
        tx_next  = `PIO_ERROR_BYTE;
        txv_next = 1'b1;
      end
      default:
      begin
        state_next = ST_WAIT_SELECT;
        txv_next   = 1'b0;
      end
    endcase
  end

  // Bus reset ends any transaction but keeps the latches
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_WAIT_SELECT;
      latch_reg <= `PIO_LATCH_RESET;
      data_reg  <= 8'h00;
      tx_reg    <= 8'hFF;
      txv_reg   <= 1'b0;
    end
    else if (ce && busReset)
    begin
      state_reg <= ST_WAIT_SELECT;
      txv_reg   <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      latch_reg <= latch_next;
      data_reg  <= data_next;
      tx_reg    <= tx_next;
      txv_reg   <= txv_next;
    end
  end

endmodule : pio_cmd_layer

// ---- pio_cmd_layer_checker.sv ----
// Port assertions for the pin access command layer
`timescale 1ns/1ps
module pio_cmd_layer_checker
  import pio_cmd_pkg::*;
(
  // Watched ports
  input wire logic ref_clk, rst, ce, busReset, romSelected, txValid, txReady, errorLoop,
  input wire pio_cmd_pkg::rx_byte_s rxByte,
  input wire pio_cmd_pkg::byte_t txData,
  input wire logic channelAPinOut, channelAPinOeN, channelBPinOut, channelBPinOeN
);
  logic armedReg;  // Next byte is a command
  always_ff @(posedge ref_clk)
    armedReg <= (rst || busReset) ? 1'b0 : (ce && romSelected) ? 1'b1 : (ce && rxByte.valid) ? 1'b0 : armedReg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rst; $fell(rst) |-> !txValid && txData == 8'hFF && channelAPinOeN && channelBPinOeN; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_read; armedReg && ce && rxByte.valid && rxByte.data == 8'hF5 |=> txValid && !errorLoop; endproperty
  a_read: assert property (p_read) else $error("no read sample");
  property p_fmt; txValid && !errorLoop && txData != 8'hAA |-> txData[7:4] == ~txData[3:0]; endproperty
  a_fmt: assert property (p_fmt) else $error("bad status form");
  property p_conf; ce && txValid && txReady && txData == 8'hAA && !busReset |=> txValid
    && txData[1] == channelAPinOeN && txData[3] == channelBPinOeN; endproperty
  a_conf: assert property (p_conf) else $error("status not after confirm");
  property p_hold; ce && txValid && !txReady && !busReset |=> txValid && $stable(txData); endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_err; errorLoop && !busReset |=> errorLoop && txValid && txData == 8'hFF; endproperty
  a_err: assert property (p_err) else $error("ones loop left");
  property p_latch; $rose(errorLoop) |-> $stable({channelAPinOeN, channelBPinOeN}); endproperty
  a_latch: assert property (p_latch) else $error("latch moved");
  property p_brst; ce && busReset |=> !txValid && !errorLoop; endproperty
  a_brst: assert property (p_brst) else $error("bus reset ignored");
  property p_out; !channelAPinOut && !channelBPinOut; endproperty
  a_out: assert property (p_out) else $error("pin driven high");
endmodule : pio_cmd_layer_checker
bind pio_cmd_layer pio_cmd_layer_checker u_pio_cmd_layer_checker (.*);

// ---- bus_master_model.sv ----
// Bus master model on the byte side of the link layer
`timescale 1ns/1ps
module bus_master_model
  import pio_cmd_pkg::*;
(
  // Link byte side
  input  wire logic             ref_clk, txValid,
  input  wire pio_cmd_pkg::byte_t txData,
  output pio_cmd_pkg::rx_byte_s rxByte,
  output logic                  romSelected, busReset, txReady
);
  initial
  begin
    rxByte = '0;
    romSelected = 1'b0;
    busReset = 1'b0;
    txReady = 1'b0;
  end
  task automatic frame();  // Reset pulse, then select
    @(posedge ref_clk) busReset <= 1'b1;
    @(posedge ref_clk) busReset <= 1'b0;
    @(posedge ref_clk) romSelected <= 1'b1;
    @(posedge ref_clk) romSelected <= 1'b0;
  endtask : frame
  task automatic send(input byte_t b);
    @(posedge ref_clk) rxByte <= '{valid: 1'b1, data: b};
    @(posedge ref_clk) rxByte <= '{valid: 1'b0, data: ~b};  // No stale byte once released
  endtask : send
  task automatic recv(output byte_t b, output bit ok);
    ok = 1'b0;
    @(posedge ref_clk) txReady <= 1'b1;
    for (int i = 0; i < 50 && !ok; i++)
    begin
      @(posedge ref_clk);
      ok = (txValid === 1'b1);
      b = txData;
    end
    txReady <= 1'b0;
  endtask : recv
endmodule : bus_master_model

// ---- pio_cmd_layer_test.sv ----
// Scenario testbench for the pin access command layer
`timescale 1ns/1ps
module pio_cmd_layer_test;
  import pio_cmd_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, pullA = 1'b0, pullB = 1'b0;
  logic busReset, romSelected, txValid, txReady, errorLoop, aOut, bOut, aOeN, bOeN;
  rx_byte_s rxByte;
  byte_t    txData;
  int       failures = 0, cmp_count = 0;
  wire pinA = aOeN & ~pullA;  // Pull-up, external switch may sink it
  wire pinB = bOeN & ~pullB;
  initial forever #4 ref_clk = ~ref_clk;
  pio_cmd_layer u_pio_cmd_layer (.ref_clk(ref_clk), .rst(rst), .ce(ce), .busReset(busReset),
    .romSelected(romSelected), .rxByte(rxByte), .txValid(txValid), .txData(txData), .txReady(txReady),
    .channelAPinIn(pinA), .channelAPinOut(aOut), .channelAPinOeN(aOeN), .channelBPinIn(pinB),
    .channelBPinOut(bOut), .channelBPinOeN(bOeN), .errorLoop(errorLoop));
  bus_master_model u_bus_master_model (.ref_clk(ref_clk), .txValid(txValid), .txData(txData),
    .rxByte(rxByte), .romSelected(romSelected), .busReset(busReset), .txReady(txReady));
  // ----------------
  // Shared tasks
  // ----------------
  task automatic close_out();
    $display("Counts: %0d compares, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic check(input byte_t seen, input byte_t exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic take(input byte_t exp);
    byte_t b;
    bit    ok;
    u_bus_master_model.recv(b, ok);
    if (!ok)
    begin
      failures++;
      close_out();
    end
    else
      check(b, exp);
  endtask : take
  task automatic t_read();
    u_bus_master_model.frame();
    @(posedge ref_clk) pullA <= 1'b1;  // Latch is one, so the switch shows
    pullB <= 1'b1;
    u_bus_master_model.send(8'hF5);
    take(8'h5A);
    @(posedge ref_clk) pullA <= 1'b0;
    pullB <= 1'b0;
    repeat (3) @(posedge ref_clk);
    take(8'h5A);
    take(8'h0F);
    check({7'h0, errorLoop}, 8'h00);
    $display("t_read done");
  endtask : t_read
  task automatic t_write();
    u_bus_master_model.frame();
    u_bus_master_model.send(8'h5A);
    u_bus_master_model.send(8'hFC);
    u_bus_master_model.send(8'h03);
    repeat (2) @(posedge ref_clk);
    take(8'hAA);
    take(8'hF0);
    check({6'h0, bOeN, aOeN}, 8'h00);
    u_bus_master_model.send(8'hFD);
    u_bus_master_model.send(8'h02);
    repeat (2) @(posedge ref_clk);
    take(8'hAA);
    take(8'hC3);
    check({6'h0, bOeN, aOeN}, 8'h01);
    $display("t_write done");
  endtask : t_write
  task automatic t_bad();
    u_bus_master_model.frame();
    u_bus_master_model.send(8'h5A);
    u_bus_master_model.send(8'hFE);
    u_bus_master_model.send(8'h00);
    repeat (2) @(posedge ref_clk);
    take(8'hFF);
    take(8'hFF);
    check({6'h0, bOeN, aOeN}, 8'h01);
    check({7'h0, errorLoop}, 8'h01);
    u_bus_master_model.frame();
    check({7'h0, errorLoop}, 8'h00);
    $display("t_bad done");
  endtask : t_bad
  task automatic t_misc();
    u_bus_master_model.frame();
    u_bus_master_model.send(8'h33);
    u_bus_master_model.send(8'hF5);
    repeat (2) @(posedge ref_clk);
    check({7'h0, txValid}, 8'h00);
    @(posedge ref_clk) ce <= 1'b0;  // Frozen: frame and command must be lost
    u_bus_master_model.frame();
    u_bus_master_model.send(8'hF5);
    @(posedge ref_clk) ce <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check({7'h0, txValid}, 8'h00);
    u_bus_master_model.frame();
    u_bus_master_model.send(8'hF5);
    take(8'hC3);
    check({6'h0, bOut, aOut}, 8'h00);
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check({6'h0, bOeN, aOeN}, 8'h03);
    check({7'h0, txValid}, 8'h00);
    $display("t_misc done");
  endtask : t_misc
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check(txData, 8'hFF);
    check({6'h0, bOeN, aOeN}, 8'h03);
    t_read();
    t_write();
    t_bad();
    t_misc();
    close_out();
  end
endmodule : pio_cmd_layer_test
